/* hpp_pins_top.sv */
// hub port pin logic: connect pull-up control, port power enables, green indicators with disable strap
// assumes a 10 MHz core clock, synchronous active-low reset and a plain strobe register port
//
// How it works
// R1: upstream power sense decides the connect pull-up
// R2: one power enable output per downstream port
// R3: power enable active level follows polarity strap
// R4: led support enabled drives greens active low
// R5: default config samples greens as disable strap
// R6: strap 00 enables all, greens active high
// R7: strap 01/10/11 disable ports, set green levels
// R8: captured straps hold until next reset
//
// Decided for this implementation: the placing of the registers and strobed register access.
module hpp_pins_top (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            upstream_power_sense,
  input  wire logic                            power_polarity_strap,
  input  wire logic [hpp_pkg::NUM_GREEN-1:0]   green_indicator_in,
  output logic      [hpp_pkg::NUM_GREEN-1:0]   green_indicator_out,
  output logic      [hpp_pkg::NUM_GREEN-1:0]   green_indicator_oe,
  output logic      [hpp_pkg::NUM_PORTS-1:0]   port_power_enable,
  output logic                                 connect_pullup_en,
  input  wire logic [hpp_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [hpp_pkg::DATA_W-1:0]      reg_wr_data,
  input  wire logic                            reg_wr_stb,
  input  wire logic                            reg_rd_stb,
  output logic      [hpp_pkg::DATA_W-1:0]      reg_rd_data
);
  import hpp_pkg::*;

  // synchronised pin levels and captured straps
  logic                 sense_level;
  logic [STRAP_W:0]     strap_level;
  logic [STRAP_W:0]     strap_value;
  logic                 strap_done;
  logic [STRAP_W-1:0]   disable_strap;
  logic                 polarity_high;

  // software state
  logic [2:0]           ctrl_reg;
  logic [2:0]           ctrl_next;
  logic [NUM_PORTS-1:0] power_req_reg;
  logic [NUM_PORTS-1:0] power_req_next;
  logic [NUM_GREEN-1:0] led_req_reg;
  logic [NUM_GREEN-1:0] led_req_next;
  logic [DATA_W-1:0]    rd_data_reg;
  logic [DATA_W-1:0]    rd_data_next;

  // pin outputs
  logic                 connect_reg;
  logic                 connect_next;
  logic [NUM_PORTS-1:0] power_pin_reg;
  logic [NUM_PORTS-1:0] power_pin_next;
  logic [NUM_GREEN-1:0] green_out_reg;
  logic [NUM_GREEN-1:0] green_out_next;
  logic [NUM_GREEN-1:0] green_oe_reg;
  logic [NUM_GREEN-1:0] green_oe_next;

  // derived configuration
  logic [NUM_PORTS-1:0] disabled_mask;
  logic [NUM_GREEN-1:0] green_active_low;
  logic                 cfg_external;
  logic                 led_support;

  // all pins pass the three-flop filter; the greens are read only while not driven
  hpp_sync3 #(
    .WIDTH (1)
  ) u_sense_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (upstream_power_sense),
    .level_reg (sense_level)
  );

  hpp_sync3 #(
    .WIDTH (STRAP_W + 1)
  ) u_strap_sync (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    ({power_polarity_strap, green_indicator_in}),
    .level_reg (strap_level)
  );

  // straps are caught once after release while the green drivers stay off, R5
  hpp_strap_capture #(
    .WIDTH         (STRAP_W + 1),
    .SETTLE_CYCLES (STRAP_SETTLE_CYCLES)
  ) u_strap_cap (
    .clk             (clk),
    .rst_b           (rst_b),
    .strap_level     (strap_level),
    .strap_value_reg (strap_value),
    .done_reg        (strap_done)
  );

  assign disable_strap = strap_value[STRAP_W-1:0];
  assign polarity_high = strap_value[STRAP_W];
  assign cfg_external  = ctrl_reg[CTRL_CFG_EXT_BIT];
  assign led_support   = ctrl_reg[CTRL_LED_EN_BIT];

  // strap decode applies only under the internal default configuration
  always_comb begin
    disabled_mask = MASK_NONE;
    if (!cfg_external) begin
      case (disable_strap)
        DIS_NONE:    disabled_mask = MASK_NONE;    // R6
        DIS_P4:      disabled_mask = MASK_P4;      // R7
        DIS_P4_P3:   disabled_mask = MASK_P4_P3;   // R7
        DIS_P4_P3_2: disabled_mask = MASK_P4_P3_2; // R7
        default:     disabled_mask = MASK_NONE;
      endcase
    end
  end

  // green active level per pin: strap bit 1 sets port 4, bit 0 sets port 3
  genvar g;
  generate
    for (g = 0; g < NUM_GREEN; g++) begin : g_green_level
      // external config with led support is always active low, default config follows the strap
      assign green_active_low[g] = cfg_external ? 1'b1 : strap_value[g]; // R4 R6 R7
    end
  endgenerate

  // register writes
  always_comb begin
    ctrl_next      = ctrl_reg;
    power_req_next = power_req_reg;
    led_req_next   = led_req_reg;
    if (reg_wr_stb) begin
      case (reg_addr)
        OFS_CTRL:  ctrl_next      = reg_wr_data[2:0];
        OFS_POWER: power_req_next = reg_wr_data[NUM_PORTS-1:0];
        OFS_LED:   led_req_next   = reg_wr_data[NUM_GREEN-1:0];
        default:   ctrl_next      = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg      <= CTRL_RESET;
      power_req_reg <= POWER_RESET;
      led_req_reg   <= LED_RESET;
    end else begin
      ctrl_reg      <= ctrl_next;
      power_req_reg <= power_req_next;
      led_req_reg   <= led_req_next;
    end
  end

  // register reads: data stand one cycle only, unmapped offsets read zero
  always_comb begin
    rd_data_next = '0;
    if (reg_rd_stb) begin
      case (reg_addr)
        OFS_CTRL:   rd_data_next[2:0]           = ctrl_reg;
        OFS_POWER:  rd_data_next[NUM_PORTS-1:0] = power_req_reg;
        OFS_LED:    rd_data_next[NUM_GREEN-1:0] = led_req_reg;
        OFS_STATUS: begin
          rd_data_next[STAT_SENSE_BIT]    = sense_level;
          rd_data_next[STAT_CONNECT_BIT]  = connect_reg;
          rd_data_next[STAT_STRAP_OK_BIT] = strap_done;
          rd_data_next[STAT_POL_BIT]      = polarity_high;
        end
        OFS_STRAP:  begin
          rd_data_next[STRAP_DIS_LSB +: STRAP_W]    = disable_strap;
          rd_data_next[STRAP_MASK_LSB +: NUM_PORTS] = disabled_mask;
        end
        default:    rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // pin drive; enables keep their reset level until the straps are known, so release adds no edge of its own
  always_comb begin
    // connect only while upstream power is present and software allows it
    connect_next = strap_done & sense_level & ctrl_reg[CTRL_CONNECT_EN_BIT]; // R1
    // one enable per port, level set by the polarity strap; after capture off means the inactive level, before it the pin stays low
    for (int p = 0; p < NUM_PORTS; p++) begin
      power_pin_next[p] = strap_done ? ~polarity_high : 1'b0;
      if (strap_done && power_req_reg[p] && !disabled_mask[p]) begin
        power_pin_next[p] = polarity_high; // R2 R3
      end
    end
    // greens stay released until captured; external config needs led support to drive them
    for (int k = 0; k < NUM_GREEN; k++) begin
      green_oe_next[k]  = strap_done & (~cfg_external | led_support); // R4 R5
      green_out_next[k] = led_req_reg[k] ^ green_active_low[k];       // R4 R6 R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      connect_reg   <= 1'b0;
      power_pin_reg <= '0;
      green_out_reg <= '0;
      green_oe_reg  <= '0;
    end else begin
      connect_reg   <= connect_next;
      power_pin_reg <= power_pin_next;
      green_out_reg <= green_out_next;
      green_oe_reg  <= green_oe_next;
    end
  end

  assign connect_pullup_en   = connect_reg;
  assign port_power_enable   = power_pin_reg;
  assign green_indicator_out = green_out_reg;
  assign green_indicator_oe  = green_oe_reg;
  assign reg_rd_data         = rd_data_reg;

endmodule

/* hpp_pkg.sv */
// package for the hub port pin and strap logic: register map, field positions, reset values, timing counts
// assumes a single 10 MHz core clock and a synchronous active-low reset
package hpp_pkg;

  // core clock
  localparam int CLK_HZ = 10_000_000;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // port counts and strap width
  localparam int NUM_PORTS  = 4;
  localparam int NUM_GREEN  = 2;
  localparam int STRAP_W    = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_POWER  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_LED    = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STRAP  = 4'h4;

  // control register fields
  localparam int CTRL_CONNECT_EN_BIT = 0;
  localparam int CTRL_CFG_EXT_BIT    = 1;
  localparam int CTRL_LED_EN_BIT     = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h1;

  // power and led request resets
  localparam logic [NUM_PORTS-1:0] POWER_RESET = 4'h0;
  localparam logic [NUM_GREEN-1:0] LED_RESET   = 2'h0;

  // status register fields
  localparam int STAT_SENSE_BIT    = 0;
  localparam int STAT_CONNECT_BIT  = 1;
  localparam int STAT_STRAP_OK_BIT = 2;
  localparam int STAT_POL_BIT      = 3;

  // strap register fields
  localparam int STRAP_DIS_LSB  = 0;
  localparam int STRAP_MASK_LSB = 2;

  // port disable strap codes
  localparam logic [STRAP_W-1:0] DIS_NONE    = 2'h0;
  localparam logic [STRAP_W-1:0] DIS_P4      = 2'h1;
  localparam logic [STRAP_W-1:0] DIS_P4_P3   = 2'h2;
  localparam logic [STRAP_W-1:0] DIS_P4_P3_2 = 2'h3;

  // disabled port masks, bit 0 is port 1
  localparam logic [NUM_PORTS-1:0] MASK_NONE    = 4'h0;
  localparam logic [NUM_PORTS-1:0] MASK_P4      = 4'h8;
  localparam logic [NUM_PORTS-1:0] MASK_P4_P3   = 4'hc;
  localparam logic [NUM_PORTS-1:0] MASK_P4_P3_2 = 4'he;

  // strap settle time after reset release, then its cycle count
  localparam int STRAP_SETTLE_NS     = 500;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_W            = 4;

endpackage

/* hpp_sync3.sv */
// three-flop input synchroniser with agreement filter
// assumes asynchronous pin inputs and the single core clock
module hpp_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_reg
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_next;

  initial begin
    if (WIDTH < 1) $error("hpp_sync3: WIDTH must be at least 1");
  end

  // a change counts only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

endmodule

/* hpp_strap_capture.sv */
// captures strap levels once after reset release and holds them until the next reset
// assumes the strap inputs are already synchronised to clk
module hpp_strap_capture #(
  parameter int WIDTH         = 3,
  parameter int SETTLE_CYCLES = 5
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] strap_level,
  output logic      [WIDTH-1:0] strap_value_reg,
  output logic                  done_reg
);
  import hpp_pkg::*;

  logic [SETTLE_W-1:0] count_reg;
  logic [SETTLE_W-1:0] count_next;
  logic [WIDTH-1:0]    strap_value_next;
  logic                done_next;

  initial begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W))
      $error("hpp_strap_capture: SETTLE_CYCLES out of range");
  end

  // wait for the synchroniser to fill with pin levels, then latch once
  always_comb begin
    count_next       = count_reg;
    strap_value_next = strap_value_reg; // R8
    done_next        = done_reg;
    if (!done_reg) begin
      if (count_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
        strap_value_next = strap_level;
        done_next        = 1'b1;
      end else begin
        count_next = count_reg + SETTLE_W'(1);
      end
    end
  end

  // captured value never changes again until reset is asserted, R8
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg       <= '0;
      strap_value_reg <= '0;
      done_reg        <= 1'b0;
    end else begin
      count_reg       <= count_next;
      strap_value_reg <= strap_value_next;
      done_reg        <= done_next;
    end
  end

endmodule

/* hpp_pins_props.sv */
// checker for the hub pin logic: strap capture timing, port 1 power enable, connect, register reads
// assumes it is bound to hpp_pins_top and sees only its ports
module hpp_pins_props (
  input wire logic                          clk,
  input wire logic                          rst_b,
  input wire logic                          upstream_power_sense,
  input wire logic                          power_polarity_strap,
  input wire logic [hpp_pkg::NUM_GREEN-1:0] green_indicator_oe,
  input wire logic [hpp_pkg::NUM_PORTS-1:0] port_power_enable,
  input wire logic                          connect_pullup_en,
  input wire logic [hpp_pkg::ADDR_W-1:0]    reg_addr,
  input wire logic [hpp_pkg::DATA_W-1:0]    reg_wr_data,
  input wire logic                          reg_wr_stb,
  input wire logic                          reg_rd_stb,
  input wire logic [hpp_pkg::DATA_W-1:0]    reg_rd_data
);
  import hpp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [NUM_PORTS-1:0] req_reg;
  logic [NUM_PORTS-1:0] req_next;

  // shadow of the power requests, since the checker cannot look inside
  always_comb begin
    req_next = req_reg;
    if (reg_wr_stb && reg_addr == OFS_POWER)
      req_next = reg_wr_data[NUM_PORTS-1:0];
  end
  always_ff @(posedge clk) begin
    if (!rst_b)
      req_reg <= POWER_RESET;
    else
      req_reg <= req_next;
  end

  // greens stay released while the straps settle, then get driven
  sequence s_settling;
    (green_indicator_oe == 2'h0) [*4];
  endsequence
  sequence s_captured;
    ##[1:4] (green_indicator_oe == 2'h3);
  endsequence

  a_capture_timing: assert property ($rose(rst_b) |-> s_settling ##0 s_captured)
    else $error("strap capture not seen in time");
  a_port1_level: assert property (green_indicator_oe != 2'h0 |->
    port_power_enable[0] == ($past(req_reg[0]) ~^ power_polarity_strap))
    else $error("port 1 power enable level wrong");
  a_connect_drop: assert property (!upstream_power_sense [*8] |-> !connect_pullup_en)
    else $error("connect held without upstream power");
  a_connect_cause: assert property ($rose(connect_pullup_en) |-> $past(upstream_power_sense, 3))
    else $error("connect raised without upstream power");
  a_rd_idle: assert property (!reg_rd_stb |=> reg_rd_data == 8'h00)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (reg_rd_stb && reg_addr > OFS_STRAP |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_status_read: assert property (reg_rd_stb && reg_addr == OFS_STATUS && green_indicator_oe == 2'h3
    |=> reg_rd_data[7:2] == {4'h0, power_polarity_strap, 1'b1})
    else $error("status read wrong");
  a_oe_paired: assert property (green_indicator_oe[1] == green_indicator_oe[0])
    else $error("green enables differ");
endmodule

/* hpp_far_model.sv */
// far side of the pin logic: port power switch, green pins with strap resistors, upstream power
// assumes the bench sets the strap pulls and the host power level
module hpp_far_model (
  input wire logic [hpp_pkg::NUM_GREEN-1:0] green_indicator_out,
  input wire logic [hpp_pkg::NUM_GREEN-1:0] green_indicator_oe,
  input wire logic [hpp_pkg::NUM_PORTS-1:0] port_power_enable,
  input wire logic                          power_polarity_strap,
  input wire logic [hpp_pkg::NUM_GREEN-1:0] strap_pull,
  input wire logic                          host_power,
  output logic     [hpp_pkg::NUM_GREEN-1:0] green_indicator_in,
  output logic                              upstream_power_sense,
  output logic     [hpp_pkg::NUM_PORTS-1:0] port_powered
);
  import hpp_pkg::*;
  // a released pin falls to its strap resistor, never keeps the last driven level
  assign green_indicator_in = (green_indicator_oe & green_indicator_out) | (~green_indicator_oe & strap_pull);
  // the switch turns a port on at the level picked by the polarity strap
  assign port_powered = power_polarity_strap ? port_power_enable : ~port_power_enable;
  assign upstream_power_sense = host_power;
endmodule

/* testbench.sv */
// self-checking bench for the hub pin logic over every strap and polarity setting
// assumes hpp_pkg, the design, the far-side model and the checker are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import hpp_pkg::*;
  logic       clk = 1'b0, rst_b = 1'b0, host_power = 1'b1, power_polarity_strap = 1'b1;
  logic       reg_wr_stb = 1'b0, reg_rd_stb = 1'b0, connect_pullup_en, upstream_power_sense;
  logic [1:0] strap_pull = 2'h0, green_indicator_in, green_indicator_out, green_indicator_oe;
  logic [3:0] reg_addr = 4'h0, port_power_enable, port_powered;
  logic [7:0] reg_wr_data = 8'h00, reg_rd_data;
  logic [3:0] mask_tab [4] = '{4'h0, 4'h8, 4'hc, 4'he};
  int         n_errors = 0;
  int         cmp_count = 0;

  always #50 clk = ~clk;

  hpp_pins_top hpp_pins_top_inst (.clk, .rst_b, .upstream_power_sense, .power_polarity_strap,
    .green_indicator_in, .green_indicator_out, .green_indicator_oe, .port_power_enable,
    .connect_pullup_en, .reg_addr, .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data);
  hpp_far_model hpp_far_model_inst (.green_indicator_out, .green_indicator_oe, .port_power_enable,
    .power_polarity_strap, .strap_pull, .host_power, .green_indicator_in, .upstream_power_sense,
    .port_powered);

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait whole cycles, then step off the edge so the design's updates have landed
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_stb <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_stb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd_stb <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_stb <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask
  task do_reset(input logic [1:0] s, input logic p);
    @(posedge clk);
    rst_b <= 1'b0;
    strap_pull <= s;
    power_polarity_strap <= p;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    settle(12);
  endtask
  // one strap code under one polarity: capture, power, greens, connect, hold
  task run_case(input logic [1:0] s, input logic p);
    logic [7:0] d;
    logic [3:0] m;
    m = mask_tab[s];
    do_reset(s, p);
    check(green_indicator_oe, 2'h3);
    check(green_indicator_out, s);
    rd(OFS_STRAP, d);
    check(d, {2'h0, m, s});
    host_power <= 1'b0;
    settle(8);
    check(connect_pullup_en, 1'b0);
    rd(OFS_STATUS, d);
    check(d, {4'h0, p, 3'h4});
    host_power <= 1'b1;
    settle(8);
    check(connect_pullup_en, 1'b1);
    rd(4'hf, d);
    check(d, 8'h00);
    wr(OFS_POWER, 8'h0f);
    settle(3);
    check(port_powered, 4'(~m));
    check(port_power_enable, p ? 4'(~m) : m);
    wr(OFS_LED, 8'h03);
    settle(2);
    check(green_indicator_out, 2'(~s));
    strap_pull <= ~s;
    wr(OFS_CTRL, 8'h07);
    settle(2);
    check(green_indicator_out, 2'h0);
    check(port_powered, 4'hf);
    wr(OFS_POWER, 8'h05);
    settle(2);
    check(port_powered, 4'h5);
    wr(OFS_CTRL, 8'h03);
    settle(2);
    check(green_indicator_oe, 2'h0);
    wr(OFS_STRAP, 8'hff);
    // let the released pins pass the filter before the default config returns
    settle(4);
    wr(OFS_CTRL, 8'h01);
    settle(2);
    check(green_indicator_out, 2'(~s));
    check(port_powered, 4'(4'h5 & ~m));
    rd(OFS_STRAP, d);
    check(d, {2'h0, m, s});
    wr(OFS_CTRL, 8'h02);
    settle(2);
    check(connect_pullup_en, 1'b0);
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 8; i++) begin
      run_case(i[1:0], i[2]);
    end
    end_sim();
  end
  // each case takes about eighty cycles, so this leaves wide margin
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule

bind hpp_pins_top hpp_pins_props hpp_pins_props_inst (.clk, .rst_b, .upstream_power_sense,
  .power_polarity_strap, .green_indicator_oe, .port_power_enable, .connect_pullup_en, .reg_addr,
  .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data);
